// ### shared/rxdw_pkg.sv
/*
 Package of the receive descriptor walker: register map, descriptor
 field layout, reset values and the decoded control word carrier.
 Assumes a 32-bit AHB-Lite register bus and 32-bit host memory words.
*/
package rxdw_pkg;

   // Register byte offsets
   localparam logic [7:0] RXDW_OFS_CTRL = 8'h00;
   localparam logic [7:0] RXDW_OFS_BASE = 8'h04;
   localparam logic [7:0] RXDW_OFS_CUR = 8'h08;
   localparam logic [7:0] RXDW_OFS_STATUS = 8'h0C;
   localparam logic [7:0] RXDW_OFS_CTLWORD = 8'h10;
   localparam logic [7:0] RXDW_OFS_NEXT = 8'h14;

   // Control register fields and base register reset value
   localparam int RXDW_CTRL_RUN_BIT = 0;
   localparam logic [31:0] RXDW_BASE_RESET = 32'h0000_0000;

   // Descriptor control word layout
   localparam int RXDW_RING_END_BIT = 25;
   localparam int RXDW_CHAINED_BIT = 24;
   localparam int RXDW_BYTES2_MSB = 21;
   localparam int RXDW_BYTES2_LSB = 11;
   localparam int RXDW_BYTES1_MSB = 10;
   localparam int RXDW_BYTES1_LSB = 0;
   localparam int RXDW_BYTES_W = 11;

   // Descriptor geometry
   localparam int RXDW_DESC_WORDS = 4;
   localparam logic [31:0] RXDW_DESC_STRIDE = 32'h0000_0010;
   localparam logic [31:0] RXDW_WORD_STRIDE = 32'h0000_0004;
   localparam logic [1:0] RXDW_IDX_CTRL = 2'h1;
   localparam logic [1:0] RXDW_IDX_BUF1 = 2'h2;
   localparam logic [1:0] RXDW_IDX_SECOND = 2'h3;

   // AHB-Lite encodings
   localparam logic [1:0] RXDW_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] RXDW_HTRANS_SEQ = 2'h3;

   typedef enum logic [2:0] {
      RXDW_ST_IDLE,
      RXDW_ST_FETCH,
      RXDW_ST_BUF1,
      RXDW_ST_BUF2,
      RXDW_ST_NEXT
   } rxdw_state_type;

   typedef struct packed {
      logic ring_end_flag;
      logic chained_next_flag;
      logic [RXDW_BYTES_W-1:0] second_buffer_bytes;
      logic [RXDW_BYTES_W-1:0] first_buffer_bytes;
   } rxdw_ctrl_type;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [RXDW_BYTES_W-1:0] bytes;
   } rxdw_buf_type;

endpackage

// ### src/rxdw_walker.sv
/*
 Receive descriptor walker: fetches four-word receive descriptors from
 host memory, decodes the control word, hands buffers to the receive
 data path one at a time and follows the ring or the chain.
 Assumes a memory read port that answers each request with one ack pulse
 carrying the word, and a data path that pulses buf_done per buffer.
*/
// Chosen here: register access over AHB-Lite and the address map.
// Summary of operation
// - A set ring-end flag makes this the last descriptor and the walk resumes at the list base afterwards.
// - With chaining set and ring end clear, the fourth word is the next descriptor address.
// - With ring end set, chaining is ignored and the fourth word is the second buffer pointer.
// - The second buffer size comes from control bits 21 to 11 and is disregarded when chained.
// - The first buffer size comes from control bits 10 to 0.
// - A zero first buffer size skips the first buffer and uses the second.
// - The first buffer pointer, read on opening a descriptor, may have any byte alignment.
// - Control bits 31 to 26 and 23 to 22 are ignored and the control word is never written back.
// - Descriptors sit on 16-byte boundaries and buffer pointers of any alignment are accepted.
`timescale 1ns/1ps

module rxdw_walker
   import rxdw_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output logic buf_valid,
   output logic [31:0] buf_addr,
   output logic [RXDW_BYTES_W-1:0] buf_bytes,
   input wire logic buf_done
);

   function automatic rxdw_ctrl_type decode_ctrl(input logic [31:0] w);
      rxdw_ctrl_type c;
      c.ring_end_flag = w[RXDW_RING_END_BIT];
      c.chained_next_flag = w[RXDW_CHAINED_BIT] & ~w[RXDW_RING_END_BIT];
      c.second_buffer_bytes = w[RXDW_CHAINED_BIT] & ~w[RXDW_RING_END_BIT] ? '0
                              : w[RXDW_BYTES2_MSB:RXDW_BYTES2_LSB];
      c.first_buffer_bytes = w[RXDW_BYTES1_MSB:RXDW_BYTES1_LSB];
      return c;
   endfunction

   // Bus slave state
   logic wr_pend_q, wr_pend_d;
   logic [7:0] wr_ofs_q, wr_ofs_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic run_q, run_d;
   logic [31:0] base_q, base_d;

   // Walker state
   rxdw_state_type state_q, state_d;
   logic [1:0] idx_q, idx_d;
   logic [31:0] cur_q, cur_d;
   logic [31:0] ctl_word_q, ctl_word_d;
   logic [31:0] ptr1_q, ptr1_d;
   logic [31:0] ptr2_q, ptr2_d;
   logic [31:0] next_q, next_d;
   logic mem_req_q, mem_req_d;
   logic [31:0] mem_addr_q, mem_addr_d;
   rxdw_buf_type buf_q, buf_d;
   logic rst_ring_q, rst_ring_d;

   rxdw_ctrl_type ctl;
   logic take;

   assign ctl = decode_ctrl(ctl_word_q);
   assign take = hsel & hready & (htrans == RXDW_HTRANS_NONSEQ || htrans == RXDW_HTRANS_SEQ);

   // Register bus
   always_comb
   begin
      wr_pend_d = 1'b0;
      wr_ofs_d = wr_ofs_q;
      hrdata_d = hrdata_q;
      run_d = run_q;
      base_d = base_q;
      if (wr_pend_q)
      begin
         case (wr_ofs_q)
            RXDW_OFS_CTRL: run_d = hwdata[RXDW_CTRL_RUN_BIT];
            RXDW_OFS_BASE: base_d = hwdata;
            default: run_d = run_q;
         endcase
      end
      if (take)
      begin
         wr_pend_d = hwrite;
         wr_ofs_d = haddr[7:0];
         hrdata_d = 32'h0000_0000;
         if (!hwrite)
         begin
            case (haddr[7:0])
               RXDW_OFS_CTRL: hrdata_d = {31'h0000_0000, run_d};
               RXDW_OFS_BASE: hrdata_d = base_d;
               RXDW_OFS_CUR: hrdata_d = cur_q;
               RXDW_OFS_STATUS: hrdata_d = {26'h000_0000, idx_q, 1'b0, state_q};
               RXDW_OFS_CTLWORD: hrdata_d = ctl_word_q;
               RXDW_OFS_NEXT: hrdata_d = next_q;
               default: hrdata_d = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_ofs_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         run_q <= 1'b0;
         base_q <= RXDW_BASE_RESET;
      end
      else
      begin
         wr_pend_q <= wr_pend_d;
         wr_ofs_q <= wr_ofs_d;
         hrdata_q <= hrdata_d;
         run_q <= run_d;
         base_q <= base_d;
      end
   end

   // Descriptor walk
   always_comb
   begin
      state_d = state_q;
      idx_d = idx_q;
      cur_d = cur_q;
      ctl_word_d = ctl_word_q;
      ptr1_d = ptr1_q;
      ptr2_d = ptr2_q;
      next_d = next_q;
      mem_req_d = mem_req_q;
      mem_addr_d = mem_addr_q;
      buf_d = buf_q;
      rst_ring_d = rst_ring_q;
      case (state_q)
         RXDW_ST_IDLE:
         begin
            if (run_q)
            begin
               if (rst_ring_q)
                  cur_d = base_q;
               rst_ring_d = 1'b0;
               idx_d = 2'h0;
               mem_req_d = 1'b1;
               mem_addr_d = rst_ring_q ? base_q : cur_q;
               state_d = RXDW_ST_FETCH;
            end
         end
         RXDW_ST_FETCH:
         begin
            if (mem_req_q && mem_ack)
            begin
               mem_req_d = 1'b0;
               case (idx_q)
                  RXDW_IDX_CTRL: ctl_word_d = mem_rdata;
                  RXDW_IDX_BUF1: ptr1_d = mem_rdata;
                  RXDW_IDX_SECOND: ptr2_d = mem_rdata;
                  default: ctl_word_d = ctl_word_q;
               endcase
               idx_d = idx_q + 2'h1;
               if (idx_q == RXDW_IDX_SECOND)
                  state_d = RXDW_ST_BUF1;
            end
            else if (!mem_req_q)
            begin
               mem_req_d = 1'b1;
               mem_addr_d = cur_q + {28'h000_0000, idx_q, 2'h0};
            end
         end
         RXDW_ST_BUF1:
         begin
            // Next descriptor: base at ring end, pointer when chained, else the next slot
            if (ctl.ring_end_flag)
               next_d = base_q;
            else if (ctl.chained_next_flag)
               next_d = ptr2_q;
            else
               next_d = cur_q + RXDW_DESC_STRIDE;
            if (!buf_q.valid)
            begin
               if (ctl.first_buffer_bytes != '0)
               begin
                  buf_d.valid = 1'b1;
                  buf_d.addr = ptr1_q;
                  buf_d.bytes = ctl.first_buffer_bytes;
               end
               else
                  state_d = RXDW_ST_BUF2;
            end
            else if (buf_done)
            begin
               buf_d.valid = 1'b0;
               state_d = RXDW_ST_BUF2;
            end
         end
         RXDW_ST_BUF2:
         begin
            if (!buf_q.valid)
            begin
               if (!ctl.chained_next_flag && ctl.second_buffer_bytes != '0)
               begin
                  buf_d.valid = 1'b1;
                  buf_d.addr = ptr2_q;
                  buf_d.bytes = ctl.second_buffer_bytes;
               end
               else
                  state_d = RXDW_ST_NEXT;
            end
            else if (buf_done)
            begin
               buf_d.valid = 1'b0;
               state_d = RXDW_ST_NEXT;
            end
         end
         RXDW_ST_NEXT:
         begin
            cur_d = next_q;
            idx_d = 2'h0;
            if (run_q)
            begin
               mem_req_d = 1'b1;
               mem_addr_d = next_q;
               state_d = RXDW_ST_FETCH;
            end
            else
               state_d = RXDW_ST_IDLE;
         end
         default:
         begin
            state_d = RXDW_ST_IDLE;
            mem_req_d = 1'b0;
            buf_d.valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= RXDW_ST_IDLE;
         idx_q <= 2'h0;
         cur_q <= RXDW_BASE_RESET;
         ctl_word_q <= 32'h0000_0000;
         ptr1_q <= 32'h0000_0000;
         ptr2_q <= 32'h0000_0000;
         next_q <= 32'h0000_0000;
         mem_req_q <= 1'b0;
         mem_addr_q <= 32'h0000_0000;
         buf_q <= '0;
         rst_ring_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         idx_q <= idx_d;
         cur_q <= cur_d;
         ctl_word_q <= ctl_word_d;
         ptr1_q <= ptr1_d;
         ptr2_q <= ptr2_d;
         next_q <= next_d;
         mem_req_q <= mem_req_d;
         mem_addr_q <= mem_addr_d;
         buf_q <= buf_d;
         rst_ring_q <= rst_ring_d;
      end
   end

   // Zero-wait OKAY slave
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign hrdata = hrdata_q;
   assign mem_req = mem_req_q;
   assign mem_addr = mem_addr_q;
   assign buf_valid = buf_q.valid;
   assign buf_addr = buf_q.addr;
   assign buf_bytes = buf_q.bytes;

endmodule

// ### bench/rxdw_mem_model.sv
/* Host memory model holding descriptor words.
   Assumes the walker's mem_req/mem_ack read port. */
`timescale 1ns/1ps
module rxdw_mem_model (
   input wire logic hclk,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic slow,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] mem [0:255];
   int w = 0;
   initial
   begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
   end
   // Read only: the control word is never written back
   always @(posedge hclk)
   begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
      begin
         if (w < (slow ? 3 : 0))
            w <= w + 1;
         else
         begin
            w <= 0;
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[9:2]];
         end
      end
   end
endmodule

// ### bench/rxdw_walker_props.sv
/* Checker of the walker's memory and buffer ports.
   Assumes it is bound to rxdw_walker. */
`timescale 1ns/1ps
module rxdw_walker_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic buf_valid,
   input wire logic [31:0] buf_addr,
   input wire logic [10:0] buf_bytes,
   input wire logic buf_done
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic acc = mem_req & mem_ack;
   logic [1:0] ix_q, ix_d;
   logic [31:0] w_q [4];
   logic [31:0] w_d [4];
   logic f_q, f_d, s_q, s_d;
   // Word 0 slot keeps the descriptor address
   always_comb
   begin
      ix_d = ix_q;
      w_d = w_q;
      f_d = f_q;
      s_d = s_q;
      if (acc)
      begin
         ix_d = ix_q + 2'h1;
         w_d[ix_q] = (ix_q == 2'h0) ? mem_addr : mem_rdata;
         f_d = f_q | (ix_q == 2'h3);
         s_d = s_q | (ix_q == 2'h3);
      end
      if (buf_valid && buf_done)
         f_d = 1'b0;
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ix_q <= 2'h0;
         w_q <= '{default: 32'h0};
         f_q <= 1'b0;
         s_q <= 1'b0;
      end
      else
      begin
         ix_q <= ix_d;
         w_q <= w_d;
         f_q <= f_d;
         s_q <= s_d;
      end
   end
   req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("request dropped");
   word_step_a: assert property (acc && ix_q != 2'h3 |=> !mem_req ##1 mem_req && mem_addr == $past(mem_addr, 2) + 32'h4)
      else $error("word order");
   next_desc_a: assert property ($rose(mem_req) && ix_q == 2'h0 && s_q && !w_q[1][25]
      |-> mem_addr == (w_q[1][24] ? w_q[3] : w_q[0] + 32'h10)) else $error("next descriptor");
   first_buf_a: assert property ($rose(buf_valid) && f_q && w_q[1][10:0] != 11'h0
      |-> buf_addr == w_q[2] && buf_bytes == w_q[1][10:0]) else $error("first buffer");
   skip_first_a: assert property ($rose(buf_valid) && f_q && w_q[1][10:0] == 11'h0
      |-> buf_addr == w_q[3] && buf_bytes == w_q[1][21:11]) else $error("skip first");
   second_buf_a: assert property ($rose(buf_valid) && !f_q
      |-> (!w_q[1][24] || w_q[1][25]) && buf_addr == w_q[3] && buf_bytes == w_q[1][21:11])
      else $error("second buffer");
   buf_hold_a: assert property (buf_valid && !buf_done |=> buf_valid && $stable({buf_addr, buf_bytes}))
      else $error("buffer changed");
   buf_drop_a: assert property (buf_valid && buf_done |=> !buf_valid)
      else $error("buffer not closed");
   cover property ($rose(buf_valid) && !f_q);
   cover property ($rose(mem_req) && s_q && w_q[1][25]);
   cover property ($rose(mem_req) && s_q && w_q[1][24] && !w_q[1][25]);
endmodule
bind rxdw_walker rxdw_walker_props u_rxdw_walker_props (.hclk, .hresetn, .mem_req, .mem_addr, .mem_ack,
   .mem_rdata, .buf_valid, .buf_addr, .buf_bytes, .buf_done);

// ### bench/rxdw_walker_bench.sv
/* Bench of the receive descriptor walker with a walk model.
   Assumes the memory model and the bound checker. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module rxdw_walker_bench;
   import rxdw_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, buf_done = 0, slow = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, ef, ea, en, r;
   wire logic hreadyout, hresp, mem_req, mem_ack, buf_valid;
   wire logic [31:0] hrdata, mem_addr, mem_rdata, buf_addr;
   wire logic [RXDW_BYTES_W-1:0] buf_bytes;
   int fail_count = 0, n_checks = 0, seed = 32'h0024, n;
   logic [31:0] qf[$], qa[$], qn[$];
   initial forever #12.5 hclk = ~hclk;
   rxdw_walker u_rxdw_walker (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
      .buf_valid, .buf_addr, .buf_bytes, .buf_done);
   rxdw_mem_model u_rxdw_mem_model (.hclk, .mem_req, .mem_addr, .slow, .mem_ack, .mem_rdata);
   task automatic test_done();
      if (fail_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wait_rdy();
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50)
      begin
         fail_count++;
         test_done();
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= RXDW_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
      `CHK("response", 1'b0, hresp)
   endtask
   task automatic desc(input int i, input logic [31:0] c, input logic [31:0] p1, input logic [31:0] p2);
      u_rxdw_mem_model.mem[i] = 32'hFFFF_FFFF;
      u_rxdw_mem_model.mem[i + 1] = c;
      u_rxdw_mem_model.mem[i + 2] = p1;
      u_rxdw_mem_model.mem[i + 3] = p2;
   endtask
   // Walk model: expected fetch addresses and buffers
   task automatic plan(input logic [31:0] base, input int cnt);
      logic [31:0] cur, c, p2;
      cur = base;
      repeat (cnt)
      begin
         for (int k = 0; k < 4; k++)
            qf.push_back(cur + 4 * k);
         c = u_rxdw_mem_model.mem[cur[9:2] + 1];
         p2 = u_rxdw_mem_model.mem[cur[9:2] + 3];
         if (c[10:0] != 11'h0)
         begin
            qa.push_back(u_rxdw_mem_model.mem[cur[9:2] + 2]);
            qn.push_back(c[10:0]);
         end
         if ((!c[24] || c[25]) && c[21:11] != 11'h0)
         begin
            qa.push_back(p2);
            qn.push_back(c[21:11]);
         end
         cur = c[25] ? base : c[24] ? p2 : cur + 32'h10;
      end
   endtask
   always @(posedge hclk)
      if (mem_req === 1'b1 && mem_ack === 1'b1 && qf.size() > 0)
      begin
         ef = qf.pop_front();
         `CHK("fetch address", ef, mem_addr)
      end
   initial
      forever
      begin
         @(posedge hclk);
         if (buf_valid === 1'b1 && qa.size() > 0)
         begin
            ea = qa.pop_front();
            en = qn.pop_front();
            `CHK("buffer address", ea, buf_addr)
            `CHK("buffer bytes", en[10:0], buf_bytes)
            repeat ($unsigned($random(seed)) % 4) @(posedge hclk);
            buf_done <= 1'b1;
            @(posedge hclk);
            buf_done <= 1'b0;
            @(posedge hclk);
         end
      end
   initial
   begin
      desc(8'h40, 32'h0000_6008, 32'h0000_1003, 32'h0000_2000);
      desc(8'h44, 32'h0100_0010, 32'h0000_3001, 32'h0000_0200);
      desc(8'h80, 32'h0300_A000, 32'h0000_5555, 32'h0000_4000);
      plan(32'h100, 12);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, RXDW_OFS_BASE, 32'h0);
      `CHK("base reset", RXDW_BASE_RESET, r)
      ahb(1'b1, RXDW_OFS_BASE, 32'h100);
      ahb(1'b0, RXDW_OFS_BASE, 32'h0);
      `CHK("base", 32'h0000_0100, r)
      ahb(1'b0, 32'h40, 32'h0);
      `CHK("unmapped", 32'h0, r)
      ahb(1'b0, RXDW_OFS_STATUS, 32'h0);
      `CHK("idle status", 32'h0, r)
      ahb(1'b1, RXDW_OFS_CTRL, 32'h1);
      ahb(1'b0, RXDW_OFS_CTRL, 32'h0);
      `CHK("run", 32'h1, r)
      n = 0;
      while (qa.size() > 0 && n < 5000)
      begin
         @(posedge hclk);
         n++;
         slow <= n[7];
      end
      if (n >= 5000)
         fail_count++;
      ahb(1'b0, RXDW_OFS_CTLWORD, 32'h0);
      `CHK("last control word", 32'h0300_A000, r)
      ahb(1'b0, RXDW_OFS_NEXT, 32'h0);
      `CHK("next descriptor", 32'h0000_0100, r)
      `CHK("fetches left", 0, qf.size())
      test_done();
   end
endmodule
